/* rtl/ubf_pkg.sv */
/*
  Constants shared by the USB parallel FIFO bridge: timing, register map,
  field positions, reset values and modes.
  Assumes a 50 MHz system clock.
*/
package ubf_pkg;

  // ----------------------------------------------------------------
  // Clock rates and times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 50;
  localparam int CORE_MHZ = 12;
  localparam int REC_MHZ  = 48;
  localparam int CLK_NS   = 20;
  localparam int MS_NS    = 1000000;
  localparam int MS_CYC   = MS_NS / CLK_NS;
  localparam int WAKE_MS  = 20;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_NVCFG  = 8'h04;
  localparam logic [7:0] OFS_TMO    = 8'h08;
  localparam logic [7:0] OFS_BAUD   = 8'h0C;
  localparam logic [7:0] OFS_DIR    = 8'h10;
  localparam logic [7:0] OFS_RXPUSH = 8'h14;
  localparam logic [7:0] OFS_TXPOP  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CHIPID = 8'h20;
  localparam logic [7:0] OFS_SERRX  = 8'h24;
  localparam logic [7:0] OFS_CRCGEN = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CFG  = 2;
  localparam int CTRL_SUSP = 3;
  localparam int NV_HD     = 0;
  localparam int NV_WAKE   = 1;
  localparam int ST_RESUME = 4;
  localparam int CRC_CLR   = 8;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  TMO_DEF    = 8'h10;
  localparam logic [7:0]  TMO_MIN    = 8'h02;
  localparam logic [15:0] BAUD_DEF   = 16'h0001;
  localparam logic        WAKE_DEF   = 1'b1;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [15:0] CRC16_RES  = 16'hB001;
  localparam logic [4:0]  CRC5_INIT  = 5'h1F;
  localparam logic [4:0]  CRC5_POLY  = 5'h14;
  localparam int          STUFF_RUN  = 6;

  // Port modes
  typedef enum logic [1:0] {
    MODE_FIFO = 2'b00,
    MODE_ABB  = 2'b01,
    MODE_SBB  = 2'b10
  } ubf_mode_t;

endpackage

/* rtl/ubf_fifo_if.sv */
/*
  Interface between the bridge core and one byte buffer.
  Assumes the buffer and its user share one clock.
*/
`timescale 1ns/1ps
interface ubf_fifo_if #(parameter int AW = 7) ();
  logic          push;
  logic [7:0]    wdat;
  logic          pop;
  logic          flush;
  logic [7:0]    head;
  logic          empty;
  logic          full;
  logic [AW:0]   level;
  modport fifo (input push, wdat, pop, flush, output head, empty, full, level);
  modport user (output push, wdat, pop, flush, input head, empty, full, level);
endinterface

/* rtl/ubf_fifo.sv */
/*
  Byte buffer with push, pop and flush, used for receive and transmit.
  Assumes DEPTH is a power of two and AW matches it.
*/
`timescale 1ns/1ps
module ubf_fifo import ubf_pkg::*; #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Buffer port
  ubf_fifo_if.fifo  f
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         rp;
    logic [AW-1:0]         wp;
    logic [AW:0]           cnt;
  } ubf_fifo_st_t;

  ubf_fifo_st_t s_r;
  ubf_fifo_st_t s_nxt;
  logic         do_pop;
  logic         do_push;

  // ----------------------------------------------------------------
  // Status and pointers
  // ----------------------------------------------------------------
  assign f.head  = s_r.mem[s_r.rp];
  assign f.empty = s_r.cnt == '0;
  assign f.full  = s_r.cnt == (AW+1)'(DEPTH);
  assign f.level = s_r.cnt;

  // Next state; a full buffer takes a push only with a pop
  always_comb begin
    s_nxt   = s_r;
    do_pop  = f.pop && !f.empty;
    do_push = f.push && (!f.full || do_pop);
    if (f.flush) begin
      s_nxt.rp  = '0;
      s_nxt.wp  = '0;
      s_nxt.cnt = '0;
    end else begin
      if (do_push) begin
        s_nxt.mem[s_r.wp] = f.wdat;
        s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (do_pop) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
      if (do_push && !do_pop) begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FIFO_GROW: assert property (@(posedge clk) disable iff (!rst_b) // R13
    (f.push && !f.full && !f.pop && !f.flush) |=> f.level == $past(f.level) + 1'b1)
    else $error("buffer did not grow on push");
  AST_FIFO_HEAD: assert property (@(posedge clk) disable iff (!rst_b) // R14
    (f.empty && f.push && !f.flush) |=> (f.head == $past(f.wdat) && !f.empty))
    else $error("pushed byte not at head of empty buffer");

endmodule

/* rtl/ubf_top.sv */
/*
  USB parallel FIFO bridge core: receive and transmit buffers, the parallel
  strobe port, bit-bang modes, receive flush timeout, remote wake-up, serial
  receive path and a classic Wishbone slave standing for the USB protocol side.
  Assumes CLK_SYS at 50 MHz; pins are asynchronous to it.
*/
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// R1 - Async bit-bang: data lines become port, buffered bytes paced out by timer.
// R2 - Sync bit-bang: pins sampled only when a byte is output.
// R3 - Fixed identification number, readable only through the USB side.
// R4 - High-drive option in nonvolatile config triples pin drive strength.
// R5 - Receive timeout flushes receive buffer; default 16 ms, 2 to 255 ms.
// R6 - Suspended with wake-up enabled: receive-available pin becomes input.
// R7 - That pin held low 20 ms or more triggers a resume request.
// R8 - Engines run from a 12 MHz reference rate.
// R9 - A 48 MHz rate derived from it serves recovery and baud timing; here baud pacing counts the 12 MHz enable.
// R10 - Recovery loop locks onto NRZI line data, yields clock and data.
// R11 - Serial engine unstuffs bits, generates CRC5/CRC16, checks received CRC.
// R12 - Control requests and vendor commands set the port parameters.
// R13 - Host data enters 128-byte receive buffer; one byte leaves per read strobe.
// R14 - Write strobe bytes enter 256-byte transmit buffer; host IN requests drain it.
// R15 - Reset at power-up and from the active-low reset input.
// R16 - Identifiers, options and user data kept in rewritable nonvolatile storage.
// R17 - Byte on data lines captured on write strobe falling edge.
// R18 - Transmit-space flag high when no write may occur.
// R19 - Receive-available low with data; read low drives byte, falling edge fetches.
// R20 - Power-enable low once configured, high during suspend.
// R21 - Strobes synchronised before edge detection; full buffer blocks writes.
module ubf_top import ubf_pkg::*; #(
  parameter int          MS_CYCLES = MS_CYC,
  parameter int          RX_DEPTH  = 128,
  parameter int          TX_DEPTH  = 256,
  parameter logic [31:0] CHIP_ID   = 32'h5A5A_0001  // Arbitrary value
) (
  // System
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  // Wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  // Parallel port
  input  wire logic [7:0]  PARALLEL_DATA_BUS_IN,
  output logic      [7:0]  PARALLEL_DATA_BUS_OUT,
  output logic      [7:0]  PARALLEL_DATA_BUS_OE_B,
  input  wire logic        RD_B,
  input  wire logic        WR,
  output logic             TX_SPACE_N,
  input  wire logic        RX_AVAIL_N_IN,
  output logic             RX_AVAIL_N,
  output logic             RX_AVAIL_OE_B,
  // Power and drive
  output logic             POWER_ON_OK_N,
  output logic             HIGH_DRIVE,
  // USB line side
  input  wire logic        USB_RXD,
  output logic             RESUME_REQ
);

  localparam int MSW = $clog2(MS_CYCLES) + 1;
  localparam int RXW = $clog2(RX_DEPTH);
  localparam int TXW = $clog2(TX_DEPTH);

  typedef struct packed {
    logic [2:0]  wr_s;
    logic [2:0]  rd_s;
    logic [1:0]  rxa_s;
    logic [1:0]  rxd_s;
    logic [7:0]  pd_a;
    logic [7:0]  pd_b;
    logic        ack;
    logic [31:0] dat;
    ubf_mode_t   mode;
    logic        configured;
    logic        suspend;
    logic        high_drive;
    logic        wake_en;
    logic [15:0] user;
    logic [7:0]  tmo;
    logic [15:0] baud;
    logic [7:0]  dir;
    logic [7:0]  pd_out;
    logic [MSW-1:0] ms_cnt;
    logic [7:0]  tmo_cnt;
    logic [7:0]  wake_cnt;
    logic        res_flag;
    logic        res_p;
    logic [5:0]  acc12;
    logic [5:0]  acc48;
    logic [15:0] baud_cnt;
    logic [1:0]  ser_ph;
    logic        ser_prev;
    logic        ser_lvl;
    logic [2:0]  ser_ones;
    logic [7:0]  ser_sh;
    logic [2:0]  ser_bits;
    logic [7:0]  ser_byte;
    logic [7:0]  ser_cnt;
    logic [15:0] ser_crc;
    logic [15:0] gen16;
    logic [4:0]  gen5;
  } ubf_top_st_t;

  ubf_top_st_t s_r;
  ubf_top_st_t s_nxt;
  logic [1:0]  rst_sync;
  logic        rst_i;
  logic [31:0] rv;
  logic [31:0] wv;
  logic [31:0] bm;
  logic        acc;
  logic [6:0]  sum12;
  logic [6:0]  sum48;
  logic        t12;
  logic        t48;
  logic        tms;
  logic        bbt;
  logic        sbit;
  logic        wake_act;
  logic [15:0] c16;
  logic [4:0]  c5;
  logic [7:0]  pd_oe;

  ubf_fifo_if #(.AW(RXW)) rx_if ();
  ubf_fifo_if #(.AW(TXW)) tx_if ();

  // ----------------------------------------------------------------
  // CRC steps, reflected
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
    crc16_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
  endfunction

  function automatic logic [4:0] crc5_bit(input logic [4:0] c, input logic b);
    crc5_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC5_POLY) : (c >> 1);
  endfunction

  // ----------------------------------------------------------------
  // Reset release and buffers
  // ----------------------------------------------------------------
  // Power-on or pin reset, released through two flops
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;  // R15
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_i = rst_sync[1];

  ubf_fifo #(.DEPTH(RX_DEPTH), .AW(RXW)) u_rx (.clk(CLK_SYS), .rst_b(rst_i), .f(rx_if.fifo));
  ubf_fifo #(.DEPTH(TX_DEPTH), .AW(TXW)) u_tx (.clk(CLK_SYS), .rst_b(rst_i), .f(tx_if.fifo));

  // ----------------------------------------------------------------
  // Pin and bus outputs
  // ----------------------------------------------------------------
  assign wake_act      = s_r.suspend && s_r.wake_en;
  assign pd_oe         = (s_r.mode == MODE_ABB || s_r.mode == MODE_SBB) ? s_r.dir : {8{!s_r.rd_s[1]}};
  assign PARALLEL_DATA_BUS_OE_B = rst_i ? ~pd_oe : 8'hFF;
  assign PARALLEL_DATA_BUS_OUT  = s_r.pd_out;
  assign TX_SPACE_N    = !rst_i || tx_if.full || s_r.mode != MODE_FIFO;  // R18 R21
  assign RX_AVAIL_N    = rx_if.empty;  // R19
  assign RX_AVAIL_OE_B = !rst_i || wake_act;  // R6
  assign POWER_ON_OK_N = !(s_r.configured && !s_r.suspend);  // R20
  assign HIGH_DRIVE    = s_r.high_drive;  // R4
  assign RESUME_REQ    = s_r.res_p;
  assign WB_ACK        = s_r.ack;
  assign WB_DAT_O      = s_r.dat;
  assign bm = {{8{WB_SEL[3]}}, {8{WB_SEL[2]}}, {8{WB_SEL[1]}}, {8{WB_SEL[0]}}};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    rx_if.push  = 1'b0;
    rx_if.wdat  = WB_DAT_I[7:0];
    rx_if.pop   = 1'b0;
    rx_if.flush = 1'b0;
    tx_if.push  = 1'b0;
    tx_if.wdat  = s_r.pd_b;
    tx_if.pop   = 1'b0;
    tx_if.flush = 1'b0;
    sbit        = 1'b0;
    c16         = s_r.gen16;
    c5          = s_r.gen5;
    bbt         = 1'b0;

    // Two-flop pin synchronisers
    s_nxt.wr_s  = {s_r.wr_s[1:0], WR};  // R21
    s_nxt.rd_s  = {s_r.rd_s[1:0], RD_B};  // R21
    s_nxt.rxa_s = {s_r.rxa_s[0], RX_AVAIL_N_IN};
    s_nxt.rxd_s = {s_r.rxd_s[0], USB_RXD};
    s_nxt.pd_a  = PARALLEL_DATA_BUS_IN;
    s_nxt.pd_b  = s_r.pd_a;

    // Fractional 12 and 48 MHz enables, millisecond tick
    sum12       = {1'b0, s_r.acc12} + 7'(CORE_MHZ);
    t12         = sum12 >= 7'(CLK_MHZ);  // R8
    s_nxt.acc12 = t12 ? 6'(sum12 - 7'(CLK_MHZ)) : sum12[5:0];
    sum48       = {1'b0, s_r.acc48} + 7'(REC_MHZ);
    t48         = sum48 >= 7'(CLK_MHZ);  // R9
    s_nxt.acc48 = t48 ? 6'(sum48 - 7'(CLK_MHZ)) : sum48[5:0];
    tms          = s_r.ms_cnt == MSW'(MS_CYCLES - 1);
    s_nxt.ms_cnt = tms ? '0 : s_r.ms_cnt + 1'b1;

    // Bit-bang pacing, period baud+1 core ticks
    if (t12) begin
      if (s_r.baud_cnt >= s_r.baud) begin
        s_nxt.baud_cnt = 16'h0000;
        bbt            = 1'b1;  // R1
      end else begin
        s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
      end
    end

    // Register readback
    case (WB_ADR)
      OFS_CTRL:   rv = {28'h0000000, s_r.suspend, s_r.configured, s_r.mode};
      OFS_NVCFG:  rv = {s_r.user, 14'h0000, s_r.wake_en, s_r.high_drive};  // R16
      OFS_TMO:    rv = {24'h000000, s_r.tmo};
      OFS_BAUD:   rv = {16'h0000, s_r.baud};
      OFS_DIR:    rv = {24'h000000, s_r.dir};
      OFS_RXPUSH: rv = 32'(rx_if.level);
      OFS_TXPOP:  rv = {23'h000000, !tx_if.empty, tx_if.head};
      OFS_STATUS: rv = {16'h0000, s_r.pd_b, 1'b0, wake_act, s_r.ser_crc == CRC16_RES, s_r.res_flag,
                        tx_if.full, tx_if.empty, rx_if.full, rx_if.empty};
      OFS_CHIPID: rv = CHIP_ID;  // R3
      OFS_SERRX:  rv = {8'h00, s_r.ser_cnt, 7'h00, s_r.ser_crc == CRC16_RES, s_r.ser_byte};
      OFS_CRCGEN: rv = {11'h000, s_r.gen5, s_r.gen16};
      default:    rv = 32'h0000_0000;
    endcase
    wv = (rv & ~bm) | (WB_DAT_I & bm);

    // Wishbone slave, one access per acknowledge
    acc       = WB_CYC && WB_STB && !s_r.ack;
    s_nxt.ack = acc;
    if (acc) begin
      s_nxt.dat = rv;
      if (WB_WE) begin
        case (WB_ADR)
          OFS_CTRL: begin
            s_nxt.mode       = ubf_mode_t'(wv[1:0]);  // R12
            s_nxt.configured = wv[CTRL_CFG];
            s_nxt.suspend    = wv[CTRL_SUSP];
          end
          OFS_NVCFG: begin
            s_nxt.high_drive = wv[NV_HD];  // R16
            s_nxt.wake_en    = wv[NV_WAKE];
            s_nxt.user       = wv[31:16];
          end
          OFS_TMO:    s_nxt.tmo  = (wv[7:0] < TMO_MIN) ? TMO_MIN : wv[7:0];  // R5
          OFS_BAUD:   s_nxt.baud = wv[15:0];
          OFS_DIR:    s_nxt.dir  = wv[7:0];
          OFS_RXPUSH: rx_if.push = WB_SEL[0];  // R13
          OFS_STATUS: s_nxt.res_flag = s_r.res_flag && !(WB_SEL[0] && WB_DAT_I[ST_RESUME]);
          OFS_SERRX:  s_nxt.ser_crc  = CRC16_INIT;
          OFS_CRCGEN: begin
            // Byte update of CRC16 and CRC5, or restart
            for (int i = 0; i < 8; i++) begin
              c16 = crc16_bit(c16, WB_DAT_I[i]);  // R11
              c5  = crc5_bit(c5, WB_DAT_I[i]);
            end
            s_nxt.gen16 = WB_DAT_I[CRC_CLR] ? CRC16_INIT : c16;
            s_nxt.gen5  = WB_DAT_I[CRC_CLR] ? CRC5_INIT : c5;
          end
          default: ;
        endcase
      end else if (WB_ADR == OFS_TXPOP) begin
        tx_if.pop = 1'b1;  // R14
      end
    end

    // Parallel port by mode
    unique case (s_r.mode)
      MODE_ABB, MODE_SBB: begin
        if (bbt) begin
          s_nxt.user[7:0] = s_r.user[7:0];
          if (!rx_if.empty && (s_r.mode == MODE_ABB || !tx_if.full)) begin
            rx_if.pop    = 1'b1;  // R1
            s_nxt.pd_out = rx_if.head;
            tx_if.push   = s_r.mode == MODE_SBB;  // R2
          end
        end
      end
      default: begin
        if (s_r.wr_s[2] && !s_r.wr_s[1] && !tx_if.full) begin
          tx_if.push = 1'b1;  // R17
        end
        if (s_r.rd_s[2] && !s_r.rd_s[1] && !rx_if.empty) begin
          rx_if.pop    = 1'b1;  // R19
          s_nxt.pd_out = rx_if.head;
        end
      end
    endcase

    // Receive flush timeout, restarted by any buffer activity
    if (rx_if.empty || rx_if.pop || rx_if.push) begin
      s_nxt.tmo_cnt = 8'h00;
    end else if (tms) begin
      if (s_r.tmo_cnt + 8'h01 >= s_r.tmo) begin
        rx_if.flush   = 1'b1;  // R5
        s_nxt.tmo_cnt = 8'h00;
      end else begin
        s_nxt.tmo_cnt = s_r.tmo_cnt + 8'h01;
      end
    end

    // Remote wake-up: full milliseconds of low input
    s_nxt.res_p = 1'b0;
    if (!wake_act || s_r.rxa_s[1]) begin
      s_nxt.wake_cnt = 8'h00;
    end else if (tms && s_r.wake_cnt <= 8'(WAKE_MS)) begin
      s_nxt.wake_cnt = s_r.wake_cnt + 8'h01;
      if (s_r.wake_cnt == 8'(WAKE_MS)) begin
        s_nxt.res_p    = 1'b1;  // R7
        s_nxt.res_flag = 1'b1;
      end
    end

    // Clock recovery, NRZI decode, unstuffing and CRC16 check
    if (t48) begin
      s_nxt.ser_prev = s_r.rxd_s[1];
      s_nxt.ser_ph   = (s_r.rxd_s[1] != s_r.ser_prev) ? 2'h0 : s_r.ser_ph + 2'h1;  // R10
      if (s_r.ser_ph == 2'h1) begin
        sbit           = s_r.rxd_s[1] == s_r.ser_lvl;
        s_nxt.ser_lvl  = s_r.rxd_s[1];
        s_nxt.ser_ones = sbit ? s_r.ser_ones + 3'h1 : 3'h0;
        if (!(s_r.ser_ones == 3'(STUFF_RUN) && !sbit)) begin
          s_nxt.ser_sh   = {sbit, s_r.ser_sh[7:1]};  // R11
          s_nxt.ser_crc  = crc16_bit(s_r.ser_crc, sbit);
          s_nxt.ser_bits = s_r.ser_bits + 3'h1;
          if (s_r.ser_bits == 3'h7) begin
            s_nxt.ser_byte = {sbit, s_r.ser_sh[7:1]};
            s_nxt.ser_cnt  = s_r.ser_cnt + 8'h01;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge rst_i) begin
    if (!rst_i) begin
      s_r          <= '0;
      s_r.rd_s     <= 3'b111;
      s_r.rxa_s    <= 2'b11;
      s_r.tmo      <= TMO_DEF;
      s_r.baud     <= BAUD_DEF;
      s_r.wake_en  <= WAKE_DEF;
      s_r.ser_crc  <= CRC16_INIT;
      s_r.gen16    <= CRC16_INIT;
      s_r.gen5     <= CRC5_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int WAKE_CYC = WAKE_MS * MS_CYCLES;
  logic [31:0] low_cyc;

  // Cycles the wake input has been low while armed
  always_ff @(posedge CLK_SYS or negedge rst_i) begin
    if (!rst_i) begin
      low_cyc <= 32'h0000_0000;
    end else begin
      low_cyc <= (wake_act && !s_r.rxa_s[1]) ? low_cyc + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!rst_i);

  sequence s_wr_fall;
    s_r.wr_s[1] ##1 !s_r.wr_s[1];
  endsequence
  sequence s_rd_fall;
    s_r.rd_s[1] ##1 (!s_r.rd_s[1] && s_r.mode == MODE_FIFO && !rx_if.empty);
  endsequence

  AST_WR_CAPTURE: assert property ( // R17
    s_wr_fall ##0 (s_r.mode == MODE_FIFO && !tx_if.full) |-> tx_if.push && tx_if.wdat == s_r.pd_b)
    else $error("write strobe byte not captured");
  AST_TX_BLOCK: assert property (tx_if.full |-> TX_SPACE_N) // R21
    else $error("write allowed into full buffer");
  AST_RD_FETCH: assert property (s_rd_fall |=> PARALLEL_DATA_BUS_OUT == $past(rx_if.head)) // R19
    else $error("read strobe did not fetch head byte");
  AST_RD_DRIVE: assert property ((s_r.mode == MODE_FIFO && !s_r.rd_s[1]) |-> PARALLEL_DATA_BUS_OE_B == 8'h00) // R19
    else $error("data lines not driven while read low");
  AST_RX_AVAIL: assert property (rx_if.push |=> !RX_AVAIL_N) // R13
    else $error("receive-available not low after push");
  AST_WAKE_INPUT: assert property (wake_act |-> RX_AVAIL_OE_B) // R6
    else $error("receive-available driven during armed suspend");
  AST_RESUME: assert property ($rose(s_r.res_p) |-> low_cyc >= 32'(WAKE_CYC)) // R7
    else $error("resume without long enough low input");
  AST_TMO_FLUSH: assert property (rx_if.flush |-> !rx_if.push && s_r.tmo >= TMO_MIN && tms) // R5
    else $error("flush outside a timeout tick");
  AST_SUSP_PWR: assert property ($rose(s_r.suspend) |=> POWER_ON_OK_N) // R20
    else $error("power enable low during suspend");
  AST_ACK_DROP: assert property (WB_ACK |=> !WB_ACK)
    else $error("acknowledge held two cycles");

endmodule

/* tb/ubf_ext_model.sv */
/*
  External logic model on the parallel port of the bridge.
  Assumes the bench clock; pins change just after rising edges.
*/
`timescale 1ns/1ps
module ubf_ext_model (
  // Clock and pins
  input  wire logic       clk,
  input  wire logic       space_n,
  input  wire logic [7:0] pins,
  output logic            wr,
  output logic            rd_b,
  output logic [7:0]      dat,
  output logic            wake_n
);
  // Idle levels
  initial begin
    wr = 1'b0;
    rd_b = 1'b1;
    dat = 8'h5A;
    wake_n = 1'b1;
  end
  // Strobe high then low, byte held over the fall
  task automatic put(input logic [7:0] b);
    if (!space_n) begin
      @(posedge clk) wr <= 1'b1;
      dat <= b;
      repeat (4) @(posedge clk);
      wr <= 1'b0;
      repeat (4) @(posedge clk);
      dat <= ~b;
    end
  endtask
  // Read strobe low, byte taken while still driven
  task automatic get(output logic [7:0] b);
    @(posedge clk) rd_b <= 1'b0;
    repeat (6) @(posedge clk);
    b = pins;
    rd_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // Wake line pulled low, then released to its pull-up
  task automatic hold(input int n);
    @(posedge clk) wake_n <= 1'b0;
    repeat (n) @(posedge clk);
    wake_n <= 1'b1;
  endtask
endmodule

/* tb/ubf_top_tb_top.sv */
/*
  Self-checking bench of the bridge, with queues as reference model.
  Assumes ubf_pkg and the external logic model are compiled first.
*/
`timescale 1ns/1ps
module ubf_top_tb_top import ubf_pkg::*; ;
  localparam int MSC = 50;
  logic clk, rst_b, cyc, stb, we, wr, rd_b, wk, ack, rdy_n, oe, pok, hd, rq, tsn;
  logic [7:0] adr, ed, po, ob, pins, b;
  logic [31:0] di, dq, q;
  logic [15:0] c16;
  logic [4:0]  c5;
  int mismatches, compares, tick, n;
  logic [31:0] seed;
  logic [7:0] txq[$], rxq[$];
  assign pins = (ed & ob) | (po & ~ob);
  ubf_top #(.MS_CYCLES(MSC)) ubf_top_inst (.CLK_SYS(clk), .RST_B(rst_b), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(di), .WB_DAT_O(dq), .WB_ACK(ack),
    .PARALLEL_DATA_BUS_IN(pins), .PARALLEL_DATA_BUS_OUT(po), .PARALLEL_DATA_BUS_OE_B(ob), .RD_B(rd_b),
    .WR(wr), .TX_SPACE_N(tsn), .RX_AVAIL_N_IN(oe ? wk : rdy_n), .RX_AVAIL_N(rdy_n), .RX_AVAIL_OE_B(oe),
    .POWER_ON_OK_N(pok), .HIGH_DRIVE(hd), .USB_RXD(1'b1), .RESUME_REQ(rq));
  ubf_ext_model ubf_ext_model_inst (.clk(clk), .space_n(tsn), .pins(pins), .wr(wr), .rd_b(rd_b),
    .dat(ed), .wake_n(wk));
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    tick++;
    if (tick == 40000) begin
      mismatches++;
      results();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {cyc, stb, we, adr, di} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dq;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_b, cyc, stb, we, adr, di} = 44'h0;
    {tick, mismatches, compares} = 96'h0;
    seed = 32'd34;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, OFS_CHIPID, 0);
    chk(q, 32'h5A5A_0001);
    wb(1'b1, OFS_CHIPID, 32'h0);
    wb(1'b0, OFS_CHIPID, 0);
    chk(q, 32'h5A5A_0001);
    wb(1'b0, 8'hFC, 0);
    chk(q, 0);
    chk({tsn, rdy_n, pok, hd}, 4'b0110);
    // Fill transmit buffer until refused, then drain
    for (int i = 0; i < 256; i++) begin
      b = rnd();
      txq.push_back(b);
      ubf_ext_model_inst.put(b);
    end
    repeat (3) @(posedge clk);
    chk(tsn, 1'b1);
    while (txq.size() > 0) begin
      wb(1'b0, OFS_TXPOP, 0);
      chk(q[8:0], {1'b1, txq.pop_front()});
    end
    wb(1'b0, OFS_TXPOP, 0);
    chk(q[8], 1'b0);
    chk(tsn, 1'b0);
    // Receive path and read strobes
    for (int i = 0; i < 130; i++) begin
      b = rnd();
      if (rxq.size() < 128) rxq.push_back(b);
      wb(1'b1, OFS_RXPUSH, {24'h0, b});
    end
    wb(1'b0, OFS_RXPUSH, 0);
    chk(q, 128);
    chk(rdy_n, 1'b0);
    repeat (3) begin
      ubf_ext_model_inst.get(b);
      chk(b, rxq.pop_front());
    end
    repeat (10 * MSC) @(posedge clk);
    chk(rdy_n, 1'b0);
    repeat (10 * MSC) @(posedge clk);
    chk(rdy_n, 1'b1);
    // Async bit-bang output
    wb(1'b1, OFS_DIR, 32'hFF);
    wb(1'b1, OFS_CTRL, 32'h1);
    b = rnd();
    wb(1'b1, OFS_RXPUSH, {24'h0, b});
    repeat (40) @(posedge clk);
    chk({ob, po}, {8'h00, b});
    // Sync bit-bang: each output byte returns the pins seen before it
    txq.push_back(b);
    wb(1'b1, OFS_CTRL, 32'h2);
    repeat (2) begin
      b = rnd();
      txq.push_back(b);
      wb(1'b1, OFS_RXPUSH, {24'h0, b});
    end
    repeat (40) @(posedge clk);
    repeat (2) begin
      wb(1'b0, OFS_TXPOP, 0);
      chk(q[8:0], {1'b1, txq.pop_front()});
    end
    chk(po, txq.pop_front());
    // Timeout floor and CRC generator against a bit-serial model
    wb(1'b1, OFS_TMO, 0);
    wb(1'b0, OFS_TMO, 0);
    chk(q, TMO_MIN);
    b = rnd();
    wb(1'b1, OFS_CRCGEN, 32'h100);
    wb(1'b1, OFS_CRCGEN, {24'h0, b});
    wb(1'b0, OFS_CRCGEN, 0);
    c16 = CRC16_INIT;
    c5 = CRC5_INIT;
    for (int i = 0; i < 8; i++) begin
      c16 = (c16[0] ^ b[i]) ? ((c16 >> 1) ^ CRC16_POLY) : (c16 >> 1);
      c5 = (c5[0] ^ b[i]) ? ((c5 >> 1) ^ CRC5_POLY) : (c5 >> 1);
    end
    chk(q[20:0], {c5, c16});
    // Configuration, drive option, suspend and wake
    wb(1'b1, OFS_NVCFG, 32'h00A5_0003);
    wb(1'b0, OFS_NVCFG, 0);
    chk(q, 32'h00A5_0003);
    wb(1'b1, OFS_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk({pok, hd}, 2'b01);
    wb(1'b1, OFS_CTRL, 32'hC);
    repeat (2) @(posedge clk);
    chk({pok, oe}, 2'b11);
    n = 0;
    fork
      ubf_ext_model_inst.hold(24 * MSC);
      while (rq !== 1'b1 && n < 24 * MSC) begin
        @(posedge clk);
        n++;
      end
    join
    chk(n >= 20 * MSC && n < 24 * MSC, 1'b1);
    wb(1'b0, OFS_STATUS, 0);
    chk(q[ST_RESUME], 1'b1);
    results();
  end
endmodule
